/* hw/cog_clock_gate_regs.sv */
module cog_clock_gate_regs (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [7:0] request_in_n,
  input  wire logic       bus_stop_n,
  output logic      [7:0] reg_rdata_q,
  output logic            reg_rvalid_q,
  output logic     [11:0] ref_run_q,
  output logic            display_run_q,
  output logic      [1:0] cpu_run_q,
  output logic            pll_spread_en_q,
  output logic            display_spread_en_q,
  output logic      [7:0] pin_out_en_q
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [7:0] reg3_q;
  logic [7:0] reg3_d;
  logic [7:0] reg4_q;
  logic [7:0] reg4_d;
  logic [7:0] reg5_q;
  logic [7:0] reg5_d;
  logic [7:0] reg6_q;
  logic [7:0] reg6_d;

  always_comb
  begin
    reg3_d = reg3_q;
    reg4_d = reg4_q;
    reg5_d = reg5_q;
    reg6_d = reg6_q;
    if (reg_wr)
    begin
      if (hit(reg_addr, cog_pkg::REF_OUTPUT_ENABLE_A_OFF))
        reg3_d = reg_wdata;
      if (hit(reg_addr, cog_pkg::OUTPUT_AND_SPREAD_ENABLE_OFF))
        reg4_d = reg_wdata;
      if (hit(reg_addr, cog_pkg::REQUEST_INPUT_CONFIG_A_OFF))
        reg5_d = reg_wdata;
      if (hit(reg_addr, cog_pkg::REQUEST_INPUT_CONFIG_B_OFF))
        reg6_d = reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg3_q <= cog_pkg::REF_OUTPUT_ENABLE_A_RST;
      reg4_q <= cog_pkg::OUTPUT_AND_SPREAD_ENABLE_RST;
      reg5_q <= cog_pkg::REQUEST_INPUT_CONFIG_A_RST;
      reg6_q <= cog_pkg::REQUEST_INPUT_CONFIG_B_RST;
    end
    else
    begin
      reg3_q <= reg3_d;
      reg4_q <= reg4_d;
      reg5_q <= reg5_d;
      reg6_q <= reg6_d;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [7:0] rdata_d;

  always_comb
  begin
    rdata_d = reg_rdata_q;
    if (reg_rd)
    begin
      rdata_d = 8'h00;
      if (hit(reg_addr, cog_pkg::REF_OUTPUT_ENABLE_A_OFF))
        rdata_d = reg3_q;
      if (hit(reg_addr, cog_pkg::OUTPUT_AND_SPREAD_ENABLE_OFF))
        rdata_d = reg4_q;
      if (hit(reg_addr, cog_pkg::REQUEST_INPUT_CONFIG_A_OFF))
        rdata_d = reg5_q;
      if (hit(reg_addr, cog_pkg::REQUEST_INPUT_CONFIG_B_OFF))
        rdata_d = reg6_q;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata_q  <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end
    else
    begin
      reg_rdata_q  <= rdata_d;
      reg_rvalid_q <= reg_rd;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers: request inputs a..h, then the stop input
  // ---------------------------------------------------------------
  logic [8:0] pin_raw;
  logic [8:0] pin_s;
  logic [7:0] req_s;
  logic       stop_s_n;

  assign pin_raw  = {bus_stop_n, request_in_n};
  assign req_s    = pin_s[7:0];
  assign stop_s_n = pin_s[8];

  generate
    for (genvar g = 0; g < 9; g++)
    begin : g_sync
      cog_sync #(
        .RST_VAL (1'b1)
      ) u_sync (
        .clock  (clock),
        .rst_b  (rst_b),
        .din    (pin_raw[g]),
        .dout_q (pin_s[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // request routing
  // ---------------------------------------------------------------
  logic [7:0]  req_en;
  logic [3:0]  tgt [cog_pkg::NUM_REQ];
  logic [12:0] claim;
  logic [12:0] grant;
  logic [12:0] req_ok;

  always_comb
  begin
    req_en[0] = reg5_q[cog_pkg::R5_A_EN];
    req_en[1] = reg5_q[cog_pkg::R5_B_EN];
    req_en[2] = reg5_q[cog_pkg::R5_C_EN];
    req_en[3] = reg5_q[cog_pkg::R5_D_EN];
    req_en[4] = reg6_q[cog_pkg::R6_E_EN];
    req_en[5] = reg6_q[cog_pkg::R6_F_EN];
    req_en[6] = reg6_q[cog_pkg::R6_G_EN];
    req_en[7] = reg6_q[cog_pkg::R6_H_EN];
    tgt[0] = reg5_q[cog_pkg::R5_A_MAP] ? 4'h2 : 4'h0;
    tgt[1] = reg5_q[cog_pkg::R5_B_MAP] ? 4'h4 : cog_pkg::TGT_DISPLAY;
    tgt[2] = reg5_q[cog_pkg::R5_C_MAP] ? 4'h2 : 4'h0;
    tgt[3] = reg5_q[cog_pkg::R5_D_MAP] ? 4'h4 : cog_pkg::TGT_DISPLAY;
    tgt[4] = 4'h6;
    tgt[5] = 4'h8;
    tgt[6] = 4'h9;
    tgt[7] = 4'ha;
    claim = 13'h0000;
    grant = 13'h0000;
    // any enabled request mapped to an output that is held low runs it
    for (int i = 0; i < cog_pkg::NUM_REQ; i++)
    begin
      if (req_en[i])
      begin
        claim[tgt[i]] = 1'b1;
        if (!req_s[i])
          grant[tgt[i]] = 1'b1;
      end
    end
    req_ok = ~claim | grant;
  end

  // ---------------------------------------------------------------
  // output gating
  // ---------------------------------------------------------------
  logic [11:0] ref_en;
  logic [11:0] ref_run_d;
  logic        display_run_d;
  logic        ref_stop;
  logic        disp_stop;

  always_comb
  begin
    ref_en     = 12'h000;
    ref_en[11] = reg3_q[cog_pkg::R3_REF11];
    ref_en[10] = reg3_q[cog_pkg::R3_REF10];
    ref_en[9]  = reg3_q[cog_pkg::R3_REF9];
    ref_en[8]  = reg3_q[cog_pkg::R3_REF8];
    ref_en[7]  = reg3_q[cog_pkg::R3_REF7];
    ref_en[6]  = reg3_q[cog_pkg::R3_REF6];
    ref_en[4]  = reg3_q[cog_pkg::R3_REF4];
    ref_en[3]  = reg4_q[cog_pkg::R4_REF3];
    ref_en[2]  = reg4_q[cog_pkg::R4_REF2];
    ref_en[0]  = reg4_q[cog_pkg::R4_REF0];
    ref_stop   = !stop_s_n && reg6_q[cog_pkg::R6_REF_STOP];
    disp_stop  = !stop_s_n && reg6_q[cog_pkg::R6_DISP_STOP];
    ref_run_d  = ref_en & req_ok[11:0] & {12{!ref_stop}};
    display_run_d = reg4_q[cog_pkg::R4_DISP] && req_ok[12] && !disp_stop;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_run_q           <= 12'h000;
      display_run_q       <= 1'b0;
      cpu_run_q           <= 2'h0;
      pll_spread_en_q     <= 1'b0;
      display_spread_en_q <= 1'b0;
      pin_out_en_q        <= 8'h00;
    end
    else
    begin
      ref_run_q           <= ref_run_d;
      display_run_q       <= display_run_d;
      cpu_run_q           <= {reg4_q[cog_pkg::R4_CPU1], reg4_q[cog_pkg::R4_CPU0]};
      pll_spread_en_q     <= reg4_q[cog_pkg::R4_PLL_SS];
      display_spread_en_q <= reg4_q[cog_pkg::R4_DISP_SS];
      pin_out_en_q        <= ~req_en;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_e_released;
    reg6_q[cog_pkg::R6_E_EN] && req_s[4];
  endsequence

  sequence s_e_asserted;
    reg6_q[cog_pkg::R6_E_EN] && !req_s[4] && reg3_q[cog_pkg::R3_REF6] && stop_s_n;
  endsequence

  property p_ref11_off;
    @(posedge clock) disable iff (!rst_b)
    reg_wr && hit(reg_addr, cog_pkg::REF_OUTPUT_ENABLE_A_OFF) && !reg_wdata[7]
      |=> ##1 !ref_run_q[11];
  endproperty
  a_ref11_off: assert property (p_ref11_off) else $error("ref11 runs while disabled");

  property p_cpu_follow;
    @(posedge clock) disable iff (!rst_b)
    $past(rst_b) |-> cpu_run_q == $past({reg4_q[3], reg4_q[2]});
  endproperty
  a_cpu_follow: assert property (p_cpu_follow) else $error("cpu run mismatch");

  property p_pll_ss;
    @(posedge clock) disable iff (!rst_b)
    reg_wr && hit(reg_addr, cog_pkg::OUTPUT_AND_SPREAD_ENABLE_OFF)
      |=> ##1 pll_spread_en_q == $past(reg_wdata[1], 2);
  endproperty
  a_pll_ss: assert property (p_pll_ss) else $error("pll spread not following write");

  property p_disp_ss;
    @(posedge clock) disable iff (!rst_b)
    $changed(reg4_q[0]) |=> display_spread_en_q == $past(reg4_q[0]);
  endproperty
  a_disp_ss: assert property (p_disp_ss) else $error("display spread mismatch");

  property p_pin_a;
    @(posedge clock) disable iff (!rst_b)
    reg5_q[cog_pkg::R5_A_EN] |=> !pin_out_en_q[0];
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin a still drives clock");

  property p_map_a_ref2;
    @(posedge clock) disable iff (!rst_b)
    reg5_q[7] && reg5_q[6] && !reg5_q[3] && req_s[0] |=> !ref_run_q[2] && ref_run_q[0] == $past(ref_en[0] && !ref_stop);
  endproperty
  a_map_a_ref2: assert property (p_map_a_ref2) else $error("request a mapped wrongly");

  property p_map_b_disp;
    @(posedge clock) disable iff (!rst_b)
    reg5_q[5] && !reg5_q[4] && !reg5_q[1] && req_s[1] |=> !display_run_q;
  endproperty
  a_map_b_disp: assert property (p_map_b_disp) else $error("request b not gating display");

  property p_e_hold;
    @(posedge clock) disable iff (!rst_b)
    s_e_released |=> !ref_run_q[6];
  endproperty
  a_e_hold: assert property (p_e_hold) else $error("ref6 runs without request");

  property p_e_run;
    @(posedge clock) disable iff (!rst_b)
    s_e_asserted |=> ref_run_q[6];
  endproperty
  a_e_run: assert property (p_e_run) else $error("ref6 stopped despite request");

  property p_disp_stop;
    @(posedge clock) disable iff (!rst_b)
    !stop_s_n && reg6_q[cog_pkg::R6_DISP_STOP] |=> !display_run_q;
  endproperty
  a_disp_stop: assert property (p_disp_stop) else $error("display runs during stop");

  property p_ref_stop;
    @(posedge clock) disable iff (!rst_b)
    !stop_s_n && reg6_q[cog_pkg::R6_REF_STOP] |=> ref_run_q == 12'h000;
  endproperty
  a_ref_stop: assert property (p_ref_stop) else $error("ref outputs run during stop");

endmodule

/* common/cog_pkg.sv */
// Overview of operation
// - reg3 enables ref outputs 11..6 and 4
// - reg4 7..2 enable ref, display, processor outputs
// - reg4 bit1 enables processor pll spread
// - reg4 bit0 enables display clock spread
// - reg5 bit7 makes bus clock0 pin request A
// - reg5 bit6 maps request A to ref0/ref2
// - reg5 bit5 makes bus clock1 pin request B
// - reg5 bit4 maps request B to display/ref4
// - reg5 bits3,2 enable and map request C
// - reg5 bit1 makes ref3 complement request D
// - reg5 bit0 maps request D to display/ref4
// - reg6 bit7 enables request E for ref6
// - reg6 bit6 enables request F for ref8
// - reg6 bit5 enables request G for ref9
// - reg6 bit4 enables request H for ref10
// - reg6 bit1 stops display clock during bus stop
// - reg6 bit0 stops ref outputs during bus stop
package cog_pkg;

  // ---------------------------------------------------------------
  // register offsets and power-up values
  // ---------------------------------------------------------------
  localparam logic [7:0] REF_OUTPUT_ENABLE_A_OFF     = 8'h03;
  localparam logic [7:0] OUTPUT_AND_SPREAD_ENABLE_OFF = 8'h04;
  localparam logic [7:0] REQUEST_INPUT_CONFIG_A_OFF  = 8'h05;
  localparam logic [7:0] REQUEST_INPUT_CONFIG_B_OFF  = 8'h06;
  localparam logic [7:0] REF_OUTPUT_ENABLE_A_RST     = 8'hff;
  localparam logic [7:0] OUTPUT_AND_SPREAD_ENABLE_RST = 8'hff;
  localparam logic [7:0] REQUEST_INPUT_CONFIG_A_RST  = 8'h00;
  localparam logic [7:0] REQUEST_INPUT_CONFIG_B_RST  = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int R3_REF11 = 7;
  localparam int R3_REF10 = 6;
  localparam int R3_REF9  = 5;
  localparam int R3_REF8  = 4;
  localparam int R3_REF7  = 3;
  localparam int R3_REF6  = 2;
  localparam int R3_REF4  = 0;
  localparam int R4_REF3  = 7;
  localparam int R4_REF2  = 6;
  localparam int R4_DISP  = 5;
  localparam int R4_REF0  = 4;
  localparam int R4_CPU1  = 3;
  localparam int R4_CPU0  = 2;
  localparam int R4_PLL_SS  = 1;
  localparam int R4_DISP_SS = 0;
  localparam int R5_A_EN  = 7;
  localparam int R5_A_MAP = 6;
  localparam int R5_B_EN  = 5;
  localparam int R5_B_MAP = 4;
  localparam int R5_C_EN  = 3;
  localparam int R5_C_MAP = 2;
  localparam int R5_D_EN  = 1;
  localparam int R5_D_MAP = 0;
  localparam int R6_E_EN  = 7;
  localparam int R6_F_EN  = 6;
  localparam int R6_G_EN  = 5;
  localparam int R6_H_EN  = 4;
  localparam int R6_DISP_STOP = 1;
  localparam int R6_REF_STOP  = 0;

  // target index 12 stands for the display clock
  localparam logic [3:0] TGT_DISPLAY = 4'hc;
  localparam int NUM_REQ    = 8;
  localparam int NUM_REF    = 12;

endpackage

/* hw/cog_sync.sv */
module cog_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      dout_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic dout_d;

  // a change counts only once the second and third stages agree
  always_comb
  begin
    dout_d = (s2_q == s3_q) ? s2_q : dout_q;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q   <= RST_VAL;
      s2_q   <= RST_VAL;
      s3_q   <= RST_VAL;
      dout_q <= RST_VAL;
    end
    else
    begin
      s1_q   <= din;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      dout_q <= dout_d;
    end
  end

endmodule

/* verif/cog_req_model.sv */
module cog_req_model (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic [7:0] want_n,
  input  wire logic       want_stop_n,
  input  wire logic [7:0] pin_out_en,
  output logic      [7:0] request_in_n,
  output logic            bus_stop_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // peripheral request lines and bus stop line
  // ---------------------------------------------------------------
  // a pin still driving its clock output toggles every cycle, never the request level
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      request_in_n <= 8'hff;
      bus_stop_n   <= 1'b1;
    end
    else
    begin
      request_in_n <= (pin_out_en & ~request_in_n) | (~pin_out_en & want_n);
      bus_stop_n   <= want_stop_n;
    end
  end
endmodule

/* verif/clock_output_gating_regs_bench.sv */
module clock_output_gating_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock       = 1'b0;
  logic        rst_b       = 1'b0;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [7:0]  reg_addr    = 8'h00;
  logic [7:0]  reg_wdata   = 8'h00;
  logic [7:0]  want_n      = 8'hff;
  logic        want_stop_n = 1'b1;
  logic [7:0]  request_in_n;
  logic        bus_stop_n;
  logic [7:0]  reg_rdata_q;
  logic        reg_rvalid_q;
  logic [11:0] ref_run_q;
  logic        display_run_q;
  logic [1:0]  cpu_run_q;
  logic        pll_spread_en_q;
  logic        display_spread_en_q;
  logic [7:0]  pin_out_en_q;
  logic [7:0]  sh [3:6];
  logic [31:0] seed        = 32'h9b9c;
  logic [7:0]  r3, r4, r5, r6;
  int          bad_count   = 0;
  int          check_count = 0;
  wire  [24:0] seen = {pin_out_en_q, cpu_run_q, pll_spread_en_q, display_spread_en_q,
                       display_run_q, ref_run_q};

  always #5 clock = ~clock;

  cog_clock_gate_regs dut_u (
    .clock(clock), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .request_in_n(request_in_n),
    .bus_stop_n(bus_stop_n), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .ref_run_q(ref_run_q), .display_run_q(display_run_q), .cpu_run_q(cpu_run_q),
    .pll_spread_en_q(pll_spread_en_q), .display_spread_en_q(display_spread_en_q),
    .pin_out_en_q(pin_out_en_q)
  );

  cog_req_model req_u (
    .clock(clock), .rst_b(rst_b), .want_n(want_n), .want_stop_n(want_stop_n),
    .pin_out_en(pin_out_en_q), .request_in_n(request_in_n), .bus_stop_n(bus_stop_n)
  );

  // ---------------------------------------------------------------
  // expectation and helpers
  // ---------------------------------------------------------------
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // target 12 is the display clock
  function automatic logic [24:0] expect_out(logic [7:0] a3, a4, a5, a6, logic [7:0] rq,
                                             logic st_n);
    logic [12:0] has;
    logic [12:0] low;
    logic [12:0] en;
    logic [12:0] run;
    logic [7:0]  act;
    int          t [8];
    act = {a6[4], a6[5], a6[6], a6[7], a5[1], a5[3], a5[5], a5[7]};
    t = '{a5[6] ? 2 : 0, a5[4] ? 4 : 12, a5[2] ? 2 : 0, a5[0] ? 4 : 12, 6, 8, 9, 10};
    has = '0;
    low = '0;
    for (int i = 0; i < 8; i++)
    begin
      has[t[i]] = has[t[i]] | act[i];
      low[t[i]] = low[t[i]] | (act[i] & ~rq[i]);
    end
    en  = {a4[5], a3[7:2], 1'b0, a3[0], a4[7], a4[6], 1'b0, a4[4]};
    run = en & (~has | low) & ~{~st_n & a6[1], {12{~st_n & a6[0]}}};
    return {~act, a4[3:0], run};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    if (a >= 8'h03 && a <= 8'h06)
      sh[a] = d;
  endtask

  task automatic rd_chk(input logic [7:0] a);
    int          i;
    logic [31:0] exp_v;
    exp_v = 32'((a >= 8'h03 && a <= 8'h06) ? sh[a] : 8'h00);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    for (i = 0; i < 3 && reg_rvalid_q !== 1'b1; i++)
    begin
      @(posedge clock);
      #1;
    end
    if (reg_rvalid_q !== 1'b1)
    begin
      bad_count++;
      $display("BAD %0t no read answer", $time);
      complete_run();
    end
    else
      check(32'(reg_rdata_q), exp_v);
  endtask

  task automatic look();
    logic [31:0] exp_v;
    repeat (8) @(posedge clock);
    #1;
    exp_v = 32'(expect_out(sh[3], sh[4], sh[5], sh[6], want_n, want_stop_n));
    check(32'(seen), exp_v);
  endtask

  task automatic do_reset();
    @(posedge clock);
    rst_b <= 1'b0;
    @(posedge clock);
    #1;
    check(32'(seen), 32'h0);
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    sh[3] = 8'hff;
    sh[4] = 8'hff;
    sh[5] = 8'h00;
    sh[6] = 8'h00;
    look();
    for (int a = 3; a <= 6; a++)
      rd_chk(a[7:0]);
    $display("test reset done");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    do_reset();
    put(8'h07, 8'h5a);
    put(8'h02, 8'h00);
    rd_chk(8'h07);
    rd_chk(8'h02);
    rd_chk(8'h03);
    $display("test unmapped done");
    put(8'h03, 8'hf7);
    put(8'h06, 8'h80);
    look();
    @(posedge clock);
    want_n <= 8'hef;
    look();
    put(8'h06, 8'h83);
    @(posedge clock);
    want_stop_n <= 1'b0;
    look();
    $display("test request walk done");
    for (int n = 0; n < 60; n++)
    begin
      put(8'h05, 8'h00);
      put(8'h06, 8'h00);
      r3 = 8'(xs());
      r4 = 8'(xs());
      r5 = 8'(xs());
      r6 = 8'(xs());
      if (r5[3] | r5[1])
        r4[7] = 1'b0;
      if (r6[7] | r6[6])
        r3[3] = 1'b0;
      if (r6[5] | r6[4])
        r3[7] = 1'b0;
      put(8'h03, r3);
      put(8'h04, r4);
      put(8'h05, r5);
      put(8'h06, r6);
      @(posedge clock);
      want_n      <= 8'(xs());
      want_stop_n <= seed[9];
      look();
      rd_chk(8'h03 + n[1:0]);
    end
    $display("test random done");
    do_reset();
    complete_run();
  end
endmodule
